// ### osc_switch_defines.vh
// Constants for the fail-safe clock switch: register map, fields, codes and timing.
`ifndef OSC_SWITCH_DEFINES_VH
`define OSC_SWITCH_DEFINES_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_CONTROL      8'h00
`define OFS_CTRL_HIGH    8'h04
`define OFS_CTRL_LOW     8'h08
`define OFS_STATUS       8'h0C

// ----------------------------------------------------------------
// Control register field positions
// ----------------------------------------------------------------
`define POS_CUR_SRC      12
`define POS_NEW_SRC      8
`define POS_FREEZE       7
`define POS_LOCK         5
`define POS_FAIL         3
`define POS_REQUEST      0

// ----------------------------------------------------------------
// Unlock keys
// ----------------------------------------------------------------
`define KEY_HIGH_1       8'h78
`define KEY_HIGH_2       8'h9A
`define KEY_LOW_1        8'h46
`define KEY_LOW_2        8'h57

// ----------------------------------------------------------------
// Source selection codes
// ----------------------------------------------------------------
`define SRC_FRC          3'h0
`define SRC_FRC_PLL      3'h1
`define SRC_PRI          3'h2
`define SRC_PRI_PLL      3'h3
`define SRC_SEC          3'h4
`define SRC_LOW_POWER_RC         3'h5

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define RESET_SRC        3'h0
`define FAIL_TIME_US     2000
`define LOW_POWER_RC_FREQ_KHZ    32
`define FAIL_TICKS       ((`FAIL_TIME_US * `LOW_POWER_RC_FREQ_KHZ) / 1000)
`define MON_DELAY_TICKS  16
`define START_CYCLES     1024

`endif

// ### clock_fail_detect.v
// Clock-failure detector: counter on low-power RC ticks cleared by system-clock activity.
`timescale 1ns/1ps
`default_nettype none
`include "osc_switch_defines.vh"

module clock_fail_detect #(
  parameter TIMEOUT_TICKS = `FAIL_TICKS
)(
  // Clock and reset
  input  wire       hclk,
  input  wire       hresetn,
  // Control and observed activity
  input  wire       enable,
  input  wire       low_power_rc_tick,
  input  wire       sys_clk_toggle,
  // Result
  output reg        failed
);

  // ----------------------------------------------------------------
  // Activity synchroniser and edge detect
  // ----------------------------------------------------------------
  reg        sync_a;
  reg        sync_b;
  reg        sync_c;
  reg [15:0] count;
  wire       activity = sync_b ^ sync_c;

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      sync_c <= 1'b0;
    end
    else
    begin
      sync_a <= sys_clk_toggle;
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end

  // ----------------------------------------------------------------
  // Timeout counter
  // ----------------------------------------------------------------
  // Any system-clock edge restarts the count, so only a stopped clock times out.
  // The count parks at the limit, so a clock that stays dead traps once, not every cycle.
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      count  <= 16'h0000;
      failed <= 1'b0;
    end
    else if (!enable || activity)
    begin
      count  <= 16'h0000;
      failed <= 1'b0;
    end
    else
    begin
      failed <= 1'b0;
      if (low_power_rc_tick && count != TIMEOUT_TICKS[15:0])
      begin
        if (count == TIMEOUT_TICKS[15:0] - 16'h0001)
          failed <= 1'b1;
        count <= count + 16'h0001;
      end
    end
  end

endmodule
`default_nettype wire

// ### fail_safe_clock_switch.v
// Fail-safe clock monitor and clock-source switch controller with an AHB-Lite register slave.
//
// Contract
// - Decode mode: switching and monitor enables.
// - Keep low-power RC on while monitoring, except Sleep.
// - No system clock for 2 ms: trap, go fast RC.
// - On failure: current=000, fail flag set, request cleared.
// - Monitor delay after reset/wake, once system reset releases.
// - Delay only with monitor on and crystal selected.
// - Delay expiring before crystal starts: trap, go fast RC.
// - Failure leaves watchdog clock running.
// - Two-speed start: fast RC first, then configured source.
// - Switch request moves clock to new selection when ready.
// - New clock ready before old one removed.
// - Control writes blocked while switching.
// - Equal selections: clear request, abort redundant switch.
// - Valid switch clears lock and fail flags.
// - Start target; wait start timer (crystal) and PLL lock (PLL source).
// - Completion clears request, copies new into current.
// - Old source off, low-power RC kept if needed.
// - Freeze bit blocks switches in mode 01, sticky.
// - High byte unlocked by 78h, 9Ah, then write.
// - Low byte unlocked by 46h, 57h, then write.
// - Unlocked byte writable for exactly one access.
// - Clearing request aborts switch, resets start timer, PLL.
// - Sleep during switch aborts, keeps old, clears request.
`timescale 1ns/1ps
`default_nettype none
`include "osc_switch_defines.vh"

module fail_safe_clock_switch #(
  parameter START_CYCLES    = `START_CYCLES,
  parameter MON_DELAY_TICKS = `MON_DELAY_TICKS,
  parameter FAIL_TICKS      = `FAIL_TICKS
)(
  // Clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [7:0]  haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  // Non-volatile configuration
  input  wire [1:0]  switch_mode_config,
  input  wire [2:0]  boot_source_sel,
  input  wire        two_speed_en,
  input  wire        watchdog_en,
  // System events
  input  wire        internal_sys_reset,
  input  wire        sleep_active,
  input  wire        wake_pulse,
  input  wire        power_up_timer_active,
  input  wire        low_power_rc_tick,
  input  wire        sys_clk_toggle,
  input  wire        pll_locked,
  // Clock control outputs
  output reg  [2:0]  sys_clk_sel,
  output reg         fast_rc_en,
  output reg         primary_en,
  output reg         secondary_en,
  output reg         low_power_rc_en,
  output reg         pll_en,
  output reg         clock_fail_trap
);

  localparam ST_IDLE = 1'b0;
  localparam ST_WAIT = 1'b1;

  // ----------------------------------------------------------------
  // Source classification
  // ----------------------------------------------------------------
  function is_crystal;
    input [2:0] s;
    begin
      is_crystal = (s == `SRC_PRI) || (s == `SRC_PRI_PLL) || (s == `SRC_SEC);
    end
  endfunction

  function uses_pll;
    input [2:0] s;
    begin
      uses_pll = (s == `SRC_FRC_PLL) || (s == `SRC_PRI_PLL);
    end
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg [2:0]  current_source_sel;
  reg [2:0]  new_source_sel;
  reg        switch_freeze;
  reg        lock_flag;
  reg        clock_fail_flag;
  reg        switch_request;
  reg        state;
  reg        booted;
  reg [1:0]  high_stage;
  reg [1:0]  low_stage;
  reg [12:0] start_count;
  reg        cur_ready;
  reg        delay_pending;
  reg [15:0] delay_count;
  reg        ph_write;
  reg [7:0]  ph_addr;

  wire switching_en = ~switch_mode_config[1];
  wire monitor_en   = (switch_mode_config == 2'b00);
  wire busy         = (state == ST_WAIT);
  wire take         = hsel & htrans[1] & hready;
  wire wr_data      = ph_write;
  wire [7:0] wbyte  = hwdata[7:0];

  // ----------------------------------------------------------------
  // Start timer and readiness
  // ----------------------------------------------------------------
  wire start_run  = busy ? is_crystal(new_source_sel) : (is_crystal(current_source_sel) & ~cur_ready);
  wire start_done = (start_count == START_CYCLES[12:0]);
  wire target_ok  = (~is_crystal(new_source_sel) | start_done)
                    & (~uses_pll(new_source_sel) | pll_locked);

  // ----------------------------------------------------------------
  // Fail-safe monitor
  // ----------------------------------------------------------------
  wire delay_applies = monitor_en & is_crystal(current_source_sel);
  wire delay_end     = delay_pending & booted & ~internal_sys_reset
                       & (~delay_applies | (low_power_rc_tick & (delay_count == MON_DELAY_TICKS[15:0] - 16'h0001)));
  wire slow_fail     = delay_end & delay_applies & ~cur_ready;
  wire mon_run       = monitor_en & ~delay_pending & ~sleep_active & ~internal_sys_reset;
  wire det_failed;
  wire fail_event    = (det_failed | slow_fail) & monitor_en;

  clock_fail_detect #(
    .TIMEOUT_TICKS (FAIL_TICKS)
  ) u_detect (
    .hclk           (hclk),
    .hresetn        (hresetn),
    .enable         (mon_run),
    .low_power_rc_tick      (low_power_rc_tick),
    .sys_clk_toggle (sys_clk_toggle),
    .failed         (det_failed)
  );

  // ----------------------------------------------------------------
  // Bus address phase and read data
  // ----------------------------------------------------------------
  // Zero wait states: read data is registered at the address phase edge.
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ph_write  <= 1'b0;
      ph_addr   <= 8'h00;
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      ph_write <= take & hwrite;
      ph_addr  <= haddr;
      if (take && !hwrite)
      begin
        case (haddr)
          `OFS_CONTROL:
            hrdata <= {16'h0000, 1'b0, current_source_sel, 1'b0, new_source_sel, switch_freeze,
                       1'b0, lock_flag, 1'b0, clock_fail_flag, 2'b00, switch_request};
          `OFS_STATUS:
            hrdata <= {28'h0000000, mon_run, delay_pending, cur_ready, busy};
          default:
            hrdata <= 32'h00000000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Unlock sequencers
  // ----------------------------------------------------------------
  // Each bus access counts as one instruction; any access not continuing a key pair relocks.
  wire any_access = take | ph_write;
  wire hi_write   = wr_data && (ph_addr == `OFS_CTRL_HIGH);
  wire lo_write   = wr_data && (ph_addr == `OFS_CTRL_LOW);
  wire hi_open    = hi_write && (high_stage == 2'h2);
  wire lo_open    = lo_write && (low_stage == 2'h2);

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      high_stage <= 2'h0;
      low_stage  <= 2'h0;
    end
    else if (wr_data)
    begin
      if (hi_write && high_stage == 2'h0 && wbyte == `KEY_HIGH_1)
        high_stage <= 2'h1;
      else if (hi_write && high_stage == 2'h1 && wbyte == `KEY_HIGH_2)
        high_stage <= 2'h2;
      else
        high_stage <= 2'h0;
      if (lo_write && low_stage == 2'h0 && wbyte == `KEY_LOW_1)
        low_stage <= 2'h1;
      else if (lo_write && low_stage == 2'h1 && wbyte == `KEY_LOW_2)
        low_stage <= 2'h2;
      else
        low_stage <= 2'h0;
    end
    else if (take)
    begin
      high_stage <= (hwrite && haddr == `OFS_CTRL_HIGH) ? high_stage : 2'h0;
      low_stage  <= (hwrite && haddr == `OFS_CTRL_LOW) ? low_stage : 2'h0;
    end
  end

  // ----------------------------------------------------------------
  // Switch sequencer and control register
  // ----------------------------------------------------------------
  // While busy only a low-byte write that drops the request gets through, so a switch can still be aborted.
  wire new_write  = hi_open & ~busy & switching_en;
  wire req_write  = lo_open & ~busy & switching_en & wbyte[`POS_REQUEST]
                    & ~(switch_freeze & ~monitor_en);
  wire abort_wr   = lo_open & busy & ~wbyte[`POS_REQUEST];
  wire freeze_wr  = lo_open & ~busy & (switch_mode_config == 2'b01) & wbyte[`POS_FREEZE];

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      current_source_sel <= `RESET_SRC;
      new_source_sel     <= `RESET_SRC;
      switch_freeze      <= 1'b0;
      lock_flag          <= 1'b0;
      clock_fail_flag    <= 1'b0;
      switch_request     <= 1'b0;
      state              <= ST_IDLE;
      booted             <= 1'b0;
      start_count        <= 13'h0000;
      cur_ready          <= 1'b0;
      clock_fail_trap    <= 1'b0;
    end
    else
    begin
      clock_fail_trap <= fail_event;
      if (start_run && !start_done)
        start_count <= start_count + 13'h0001;
      if (start_done && !busy)
        cur_ready <= 1'b1;
      if (uses_pll(busy ? new_source_sel : current_source_sel) && pll_locked)
        lock_flag <= 1'b1;
      if (wake_pulse)
        cur_ready <= ~is_crystal(current_source_sel);
      if (freeze_wr)
        switch_freeze <= 1'b1;
      if (new_write)
        new_source_sel <= wbyte[2:0];
      if (!booted)
      begin
        booted         <= 1'b1;
        new_source_sel <= boot_source_sel;
        cur_ready      <= ~is_crystal(boot_source_sel);
        if (two_speed_en && boot_source_sel != `SRC_FRC)
        begin
          current_source_sel <= `SRC_FRC;
          cur_ready          <= 1'b1;
          switch_request     <= 1'b1;
          state              <= ST_WAIT;
          start_count        <= 13'h0000;
        end
        else
          current_source_sel <= boot_source_sel;
      end
      else if (fail_event)
      begin
        current_source_sel <= `SRC_FRC;
        clock_fail_flag    <= 1'b1;
        switch_request     <= 1'b0;
        state              <= ST_IDLE;
        cur_ready          <= 1'b1;
        start_count        <= 13'h0000;
      end
      else
      begin
        case (state)
          ST_IDLE:
          begin
            if (req_write)
            begin
              if (new_source_sel == current_source_sel)
                switch_request <= 1'b0;
              else
              begin
                switch_request  <= 1'b1;
                lock_flag       <= 1'b0;
                clock_fail_flag <= 1'b0;
                state           <= ST_WAIT;
                start_count     <= 13'h0000;
              end
            end
          end
          ST_WAIT:
          begin
            if (abort_wr || sleep_active)
            begin
              switch_request <= 1'b0;
              state          <= ST_IDLE;
              start_count    <= 13'h0000;
            end
            else if (target_ok)
            begin
              current_source_sel <= new_source_sel;
              switch_request     <= 1'b0;
              cur_ready          <= 1'b1;
              state              <= ST_IDLE;
              start_count        <= 13'h0000;
            end
          end
          default:
            state <= ST_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Monitor delay after reset or wake
  // ----------------------------------------------------------------
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      delay_pending <= 1'b1;
      delay_count   <= 16'h0000;
    end
    else if (wake_pulse)
    begin
      delay_pending <= 1'b1;
      delay_count   <= 16'h0000;
    end
    else if (delay_end)
      delay_pending <= 1'b0;
    else if (delay_pending && !internal_sys_reset && low_power_rc_tick)
      delay_count <= delay_count + 16'h0001;
  end

  // ----------------------------------------------------------------
  // Oscillator enables
  // ----------------------------------------------------------------
  // The target runs beside the old source until the handover, then the old one drops.
  wire [2:0] cur_next = fail_event ? `SRC_FRC : current_source_sel;
  wire       tgt_on   = busy & ~fail_event;

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sys_clk_sel     <= `RESET_SRC;
      fast_rc_en      <= 1'b1;
      primary_en      <= 1'b0;
      secondary_en    <= 1'b0;
      low_power_rc_en <= 1'b1;
      pll_en          <= 1'b0;
    end
    else
    begin
      sys_clk_sel  <= current_source_sel;
      fast_rc_en   <= (cur_next == `SRC_FRC) || (cur_next == `SRC_FRC_PLL) || (tgt_on
                      && (new_source_sel == `SRC_FRC || new_source_sel == `SRC_FRC_PLL));
      primary_en   <= (cur_next == `SRC_PRI) || (cur_next == `SRC_PRI_PLL) || (tgt_on
                      && (new_source_sel == `SRC_PRI || new_source_sel == `SRC_PRI_PLL));
      secondary_en <= (cur_next == `SRC_SEC) || (tgt_on && new_source_sel == `SRC_SEC);
      pll_en       <= uses_pll(cur_next) || (tgt_on && uses_pll(new_source_sel));
      low_power_rc_en <= ~sleep_active & (monitor_en | watchdog_en | power_up_timer_active
                         | (cur_next == `SRC_LOW_POWER_RC) | (tgt_on && new_source_sel == `SRC_LOW_POWER_RC));
    end
  end

endmodule
`default_nettype wire

// ### clock_switch_monitor.sv
// Checker on the clock-control outputs of the fail-safe clock switch.
`timescale 1ns/1ps
`default_nettype none
`include "osc_switch_defines.vh"
module clock_switch_monitor (
  // Clock and reset
  input wire logic       hclk,
  input wire logic       hresetn,
  // Configuration and events
  input wire logic [1:0] switch_mode_config,
  input wire logic       watchdog_en,
  input wire logic       sleep_active,
  input wire logic       pll_locked,
  // Clock control outputs
  input wire logic [2:0] sys_clk_sel,
  input wire logic       fast_rc_en,
  input wire logic       primary_en,
  input wire logic       secondary_en,
  input wire logic       low_power_rc_en,
  input wire logic       pll_en,
  input wire logic       clock_fail_trap
);
  // ----------------------------------------
  // Output relations.
  // ----------------------------------------
  // The enable that the selected source needs; a switch must never land on a stopped oscillator.
  wire logic sel_on;
  wire logic pri_sel;
  assign sel_on = (sys_clk_sel == `SRC_FRC)     ? fast_rc_en :
                  (sys_clk_sel == `SRC_FRC_PLL) ? fast_rc_en & pll_en :
                  (sys_clk_sel == `SRC_PRI)     ? primary_en :
                  (sys_clk_sel == `SRC_PRI_PLL) ? primary_en & pll_en :
                  (sys_clk_sel == `SRC_SEC)     ? secondary_en : low_power_rc_en;
  assign pri_sel = (sys_clk_sel == `SRC_PRI) || (sys_clk_sel == `SRC_PRI_PLL);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  property p_mode_off; (switch_mode_config != 2'h0) |-> !clock_fail_trap; endproperty
  a_mode_off: assert property (p_mode_off) else $error("trap with monitor disabled");
  property p_low_power_rc_on; (switch_mode_config == 2'h0 || watchdog_en) && !sleep_active && !$past(sleep_active)
    |-> low_power_rc_en; endproperty
  a_low_power_rc_on: assert property (p_low_power_rc_on) else $error("low-power RC stopped");
  property p_trap_frc; clock_fail_trap |-> ##[0:1] (sys_clk_sel == `SRC_FRC); endproperty
  a_trap_frc: assert property (p_trap_frc) else $error("trap without fast RC selection");
  property p_trap_pulse; clock_fail_trap |=> !clock_fail_trap; endproperty
  a_trap_pulse: assert property (p_trap_pulse) else $error("trap longer than one cycle");
  property p_make; $changed(sys_clk_sel) |-> sel_on; endproperty
  a_make: assert property (p_make) else $error("switched onto a stopped source");
  property p_old_pri; $changed(sys_clk_sel) && $past(pri_sel) && !pri_sel |-> !primary_en; endproperty
  a_old_pri: assert property (p_old_pri) else $error("old primary left running");
  property p_pll_lock; $changed(sys_clk_sel) && (sys_clk_sel == `SRC_FRC_PLL || sys_clk_sel == `SRC_PRI_PLL)
    |-> $past(pll_locked); endproperty
  a_pll_lock: assert property (p_pll_lock) else $error("PLL source taken before lock");
  property p_sleep; sleep_active && $past(sleep_active) && $past(sleep_active, 2) |-> $stable(sys_clk_sel);
  endproperty
  a_sleep: assert property (p_sleep) else $error("selection moved during sleep");
endmodule
bind fail_safe_clock_switch clock_switch_monitor u_mon (
  .hclk(hclk), .hresetn(hresetn), .switch_mode_config(switch_mode_config), .watchdog_en(watchdog_en),
  .sleep_active(sleep_active), .pll_locked(pll_locked), .sys_clk_sel(sys_clk_sel), .fast_rc_en(fast_rc_en),
  .primary_en(primary_en), .secondary_en(secondary_en), .low_power_rc_en(low_power_rc_en), .pll_en(pll_en),
  .clock_fail_trap(clock_fail_trap)
);
`default_nettype wire

// ### tb_top.sv
// Self-checking testbench for the fail-safe clock switch.
`timescale 1ns/1ps
`default_nettype none
`include "osc_switch_defines.vh"
module tb_top;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, two_speed_en, watchdog_en, sleep_active;
  logic        internal_sys_reset, wake_pulse, power_up_timer_active, low_power_rc_tick, sys_clk_toggle, pll_locked;
  logic        alive, got, fast_rc_en, primary_en, secondary_en, low_power_rc_en, pll_en, clock_fail_trap;
  logic [1:0]  htrans, switch_mode_config;
  logic [2:0]  hsize, boot_source_sel, sys_clk_sel;
  logic [7:0]  haddr;
  logic [31:0] hwdata, hrdata, rdat;
  int          n_mismatch, checks, tick_cnt;
  fail_safe_clock_switch #(.START_CYCLES(64), .MON_DELAY_TICKS(2), .FAIL_TICKS(4)) u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .switch_mode_config(switch_mode_config), .boot_source_sel(boot_source_sel), .two_speed_en(two_speed_en),
    .watchdog_en(watchdog_en), .internal_sys_reset(internal_sys_reset), .sleep_active(sleep_active),
    .wake_pulse(wake_pulse), .power_up_timer_active(power_up_timer_active), .low_power_rc_tick(low_power_rc_tick),
    .sys_clk_toggle(sys_clk_toggle), .pll_locked(pll_locked), .sys_clk_sel(sys_clk_sel),
    .fast_rc_en(fast_rc_en), .primary_en(primary_en), .secondary_en(secondary_en),
    .low_power_rc_en(low_power_rc_en), .pll_en(pll_en), .clock_fail_trap(clock_fail_trap));
  // ----------------------------------------
  // Clock, ticks and bus tasks.
  // ----------------------------------------
  initial
  begin
    hclk = 1'h0;
    forever #20 hclk = ~hclk;
  end
  // Low-power RC ticks every eighth cycle; the system clock shows activity only while alive is set.
  always @(posedge hclk)
  begin
    tick_cnt <= tick_cnt + 1;
    low_power_rc_tick <= (tick_cnt % 8 == 7);
    if (alive)
      sys_clk_toggle <= ~sys_clk_toggle;
  end
  task automatic end_sim;
    if (n_mismatch == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Waits for a rising edge with hready high; a slave that never answers ends the run.
  task automatic edge_ready;
    bit ok;
    ok = 1'h0;
    for (int k = 0; k < 50 && !ok; k++)
    begin
      @(posedge hclk);
      ok = (hreadyout === 1'h1);
    end
    if (!ok)
    begin
      n_mismatch++;
      end_sim;
    end
  endtask
  task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    edge_ready;
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    edge_ready;
    rdat = hrdata;
  endtask
  task automatic hi(input logic [7:0] v);
    acc(1'h1, `OFS_CTRL_HIGH, 32'h78);
    acc(1'h1, `OFS_CTRL_HIGH, 32'h9A);
    acc(1'h1, `OFS_CTRL_HIGH, {24'h000000, v});
  endtask
  task automatic lo(input logic [7:0] v);
    acc(1'h1, `OFS_CTRL_LOW, 32'h46);
    acc(1'h1, `OFS_CTRL_LOW, 32'h57);
    acc(1'h1, `OFS_CTRL_LOW, {24'h000000, v});
  endtask
  // Polls the busy flag; a switch that never finishes counts as a mismatch.
  task automatic idle_wait;
    int k;
    for (k = 0; k < 100; k++)
    begin
      acc(1'h0, `OFS_STATUS, 32'h0);
      if (rdat[0] === 1'h0)
        break;
    end
    chk("busy", {31'h0, rdat[0]}, 32'h0);
  endtask
  task automatic wtrap(input int n);
    got = 1'h0;
    for (int k = 0; k < n && !got; k++)
    begin
      @(posedge hclk);
      got = (clock_fail_trap === 1'h1);
    end
  endtask
  task automatic rst(input logic [1:0] m, input logic [2:0] b, input logic two);
    @(posedge hclk);
    hresetn <= 1'h0;
    internal_sys_reset <= 1'h1;
    switch_mode_config <= m;
    boot_source_sel <= b;
    two_speed_en <= two;
    watchdog_en <= m[1];
    repeat (8) @(posedge hclk);
    hresetn <= 1'h1;
    internal_sys_reset <= 1'h0;
  endtask
  // ----------------------------------------
  // Scenarios.
  // ----------------------------------------
  task automatic t_regs;
    acc(1'h1, 8'h10, 32'hFFFFFFFF);
    acc(1'h0, 8'h10, 32'h0);
    chk("unmapped", rdat, 32'h0);
    chk("hresp", {31'h0, hresp}, 32'h0);
    hi(`SRC_FRC);
    lo(8'h01);
    acc(1'h0, `OFS_CONTROL, 32'h0);
    chk("redundant", rdat & 32'h7009, 32'h0);
    hi(`SRC_SEC);
    acc(1'h1, `OFS_CTRL_HIGH, 32'h02);
    acc(1'h0, `OFS_CONTROL, 32'h0);
    chk("one write", rdat & 32'h0700, 32'h0400);
  endtask
  task automatic t_pll;
    hi(`SRC_FRC_PLL);
    lo(8'h01);
    acc(1'h0, `OFS_CONTROL, 32'h0);
    chk("start", rdat & 32'h7029, 32'h0001);
    chk("pll on", {31'h0, pll_en}, 32'h1);
    hi(`SRC_PRI);
    acc(1'h0, `OFS_CONTROL, 32'h0);
    chk("blocked", rdat & 32'h0700, 32'h0100);
    pll_locked <= 1'h1;
    idle_wait;
    acc(1'h0, `OFS_CONTROL, 32'h0);
    chk("pll done", rdat & 32'h7021, 32'h1020);
    chk("sel", {29'h0, sys_clk_sel}, 32'h1);
    hi(`SRC_PRI);
    lo(8'h01);
    idle_wait;
    pll_locked <= 1'h0;
    acc(1'h0, `OFS_CONTROL, 32'h0);
    chk("pri done", rdat & 32'h7001, 32'h2000);
    chk("old off", {30'h0, pll_en, fast_rc_en}, 32'h0);
  endtask
  task automatic t_abort;
    hi(`SRC_SEC);
    lo(8'h01);
    lo(8'h00);
    acc(1'h0, `OFS_CONTROL, 32'h0);
    chk("abort", rdat & 32'h7001, 32'h2000);
    chk("sec off", {31'h0, secondary_en}, 32'h0);
  endtask
  task automatic t_fail;
    wtrap(100);
    chk("no trap", {31'h0, got}, 32'h0);
    hi(`SRC_SEC);
    lo(8'h01);
    alive <= 1'h0;
    wtrap(300);
    alive <= 1'h1;
    chk("trap", {31'h0, got}, 32'h1);
    acc(1'h0, `OFS_CONTROL, 32'h0);
    chk("fail", rdat & 32'h7009, 32'h0008);
    hi(`SRC_PRI);
    lo(8'h01);
    acc(1'h0, `OFS_CONTROL, 32'h0);
    chk("fail clr", rdat & 32'h0009, 32'h0001);
    idle_wait;
    rst(2'h0, `SRC_PRI, 1'h0);
    wtrap(300);
    chk("delay trap", {31'h0, got}, 32'h1);
    acc(1'h0, `OFS_CONTROL, 32'h0);
    chk("delay fail", rdat & 32'h7008, 32'h0008);
  endtask
  task automatic t_two;
    rst(2'h1, `SRC_PRI, 1'h1);
    acc(1'h0, `OFS_CONTROL, 32'h0);
    chk("fast first", rdat & 32'h7001, 32'h0001);
    idle_wait;
    hi(`SRC_SEC);
    lo(8'h01);
    sleep_active <= 1'h1;
    repeat (3) @(posedge hclk);
    sleep_active <= 1'h0;
    acc(1'h0, `OFS_CONTROL, 32'h0);
    chk("sleep", rdat & 32'h7001, 32'h2000);
    lo(8'h80);
    lo(8'h00);
    hi(`SRC_SEC);
    lo(8'h01);
    acc(1'h0, `OFS_CONTROL, 32'h0);
    chk("frozen", rdat & 32'h7081, 32'h2080);
  endtask
  task automatic t_off;
    rst(2'h2, `SRC_PRI, 1'h0);
    hi(`SRC_SEC);
    lo(8'h01);
    alive <= 1'h0;
    wtrap(200);
    alive <= 1'h1;
    chk("no monitor", {31'h0, got}, 32'h0);
    acc(1'h0, `OFS_CONTROL, 32'h0);
    chk("no switch", rdat & 32'h7000, 32'h2000);
    chk("low_power_rc kept", {31'h0, low_power_rc_en}, 32'h1);
  endtask
  initial
  begin
    {hresetn, hsel, hwrite, two_speed_en, watchdog_en, sleep_active, wake_pulse} = 7'h00;
    {power_up_timer_active, pll_locked, sys_clk_toggle, low_power_rc_tick, htrans} = 6'h00;
    {switch_mode_config, boot_source_sel, haddr, hwdata} = 45'h0;
    hsize = 3'h2;
    internal_sys_reset = 1'h1;
    alive = 1'h1;
    n_mismatch = 0;
    checks = 0;
    tick_cnt = 0;
    rst(2'h0, `SRC_FRC, 1'h0);
    t_regs;
    t_pll;
    t_abort;
    t_fail;
    t_two;
    t_off;
    end_sim;
  end
endmodule
`default_nettype wire
